// ---- rtl/ueh_pkg.sv ----
// ============================================================
// ueh_pkg: register map, field positions and states of the
// usb endpoint state and host interrupt block.
// assumes a 32-bit classic wishbone slave port, word addressed.
// ============================================================
package ueh_pkg;

    // ========================================================
    // register indices (byte address is four times the index)
    localparam logic [8:0] IDX_HOST_IEN_CLR = 9'h008;
    localparam logic [8:0] IDX_HOST_IEN_SET = 9'h009;
    localparam logic [8:0] IDX_HOST_FLAGS   = 9'h01C;
    localparam logic [8:0] IDX_EP_CLR       = 9'h104;
    localparam logic [8:0] IDX_EP_SET       = 9'h105;
    localparam logic [8:0] IDX_EP_STATE     = 9'h106;
    localparam logic [8:0] IDX_EP_FLAGS     = 9'h107;
    localparam logic [8:0] IDX_EP_IEN       = 9'h108;

    // ========================================================
    // endpoint state fields
    localparam int B_BANK0_READY = 6;
    localparam int B_STALL_REQ   = 4;
    localparam int B_CUR_BANK    = 2;
    localparam int B_IN_TOGGLE   = 1;
    localparam int B_OUT_TOGGLE  = 0;
    localparam logic [7:0] EP_STATE_MASK  = 8'h57;
    localparam logic [7:0] EP_STATE_RESET = 8'h00;

    // endpoint flag fields
    localparam int B_EP_OUT_DONE = 0;
    localparam int B_EP_IN_DONE  = 1;
    localparam int B_EP_SETUP    = 4;
    localparam int B_EP_STALLED  = 5;
    localparam logic [7:0] EP_FLAG_MASK  = 8'h33;
    localparam logic [7:0] EP_FLAG_RESET = 8'h00;

    // host flag and enable fields, one shared layout
    localparam int B_UP_RESUME = 6;
    localparam int B_DN_RESUME = 5;
    localparam int B_WAKE_UP   = 4;
    localparam int B_BUS_RESET = 3;
    localparam int B_FRAME_ST  = 2;
    localparam int B_DEV_CONN  = 8;
    localparam int B_DEV_DISC  = 9;
    localparam logic [15:0] HOST_MASK  = 16'h037C;
    localparam logic [15:0] HOST_RESET = 16'h0000;

    // handshake sequencer states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_RESPOND = 2'b10
    } ueh_state_type;

endpackage : ueh_pkg

// ---- rtl/ueh_sync.sv ----
// ============================================================
// ueh_sync: two-flop synchroniser for pin-level inputs.
// assumes the inputs are quasi-static levels, not pulses.
// ============================================================
`timescale 1ns/1ns
module ueh_sync #(
    parameter int W = 1
) (
    // clock and control
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    // first stage is read only by the second stage
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_reg[g] <= 1'b0;
                    sync_o[g]   <= 1'b0;
                end else if (ce_i) begin
                    meta_reg[g] <= async_i[g];
                    sync_o[g]   <= meta_reg[g];
                end
            end
        end
    endgenerate

endmodule : ueh_sync

// ---- rtl/ueh_ep_state.sv ----
// ============================================================
// ueh_ep_state: endpoint state bits with set/clear strobes.
// assumes strobes and link events share the block clock.
// ============================================================
`timescale 1ns/1ns
module ueh_ep_state (
    // clock and control
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // software strobes, one cycle
    input  wire logic [7:0] sw_set_i,
    input  wire logic [7:0] sw_clr_i,
    // link events, one cycle
    input  wire logic       setup_rcvd_i,
    input  wire logic       in_ack_i,
    input  wire logic       out_data_ok_i,
    // state
    output logic      [7:0] state_o
);
    logic [7:0] hw_next;
    logic [7:0] state_next;

    // hardware first, then software clear, then set wins
    always_comb begin
        hw_next = state_o;
        if (setup_rcvd_i) hw_next[ueh_pkg::B_STALL_REQ] = 1'b0;
        if (in_ack_i) begin
            hw_next[ueh_pkg::B_BANK0_READY] = 1'b0;
            hw_next[ueh_pkg::B_IN_TOGGLE]   = ~state_o[ueh_pkg::B_IN_TOGGLE];
        end
        if (out_data_ok_i) begin
            hw_next[ueh_pkg::B_BANK0_READY] = 1'b1;
            hw_next[ueh_pkg::B_OUT_TOGGLE]  = ~state_o[ueh_pkg::B_OUT_TOGGLE];
        end
        state_next = ((hw_next & ~sw_clr_i) | sw_set_i)
                     & ueh_pkg::EP_STATE_MASK;
    end

    // state register, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_o <= ueh_pkg::EP_STATE_RESET;
        end else if (ce_i) begin
            state_o <= state_next;
        end
    end

endmodule : ueh_ep_state

// ---- rtl/ueh_ctrl.sv ----
// ============================================================
// ueh_ctrl: endpoint state, handshake answer and host interrupt
// logic behind a classic wishbone slave.
// assumes link events are one-cycle pulses on clk_i and the
// attach pin is asynchronous.
// ============================================================
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
module ueh_ctrl (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [10:2] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // link events from the protocol engine
    input  wire logic        bus_reset_evt_i,
    input  wire logic        frame_start_evt_i,
    input  wire logic        up_resume_evt_i,
    input  wire logic        dn_resume_evt_i,
    input  wire logic        wake_up_evt_i,
    input  wire logic        setup_rcvd_i,
    input  wire logic        in_token_i,
    input  wire logic        out_token_i,
    input  wire logic        in_ack_i,
    input  wire logic        out_data_ok_i,
    // attach detect pin
    input  wire logic        dev_attached_i,
    // handshake answer to the link
    output logic             hs_stall_o,
    output logic             hs_nak_o,
    output logic             hs_ack_o,
    output logic             tx_data_o,
    output logic             pid_data1_o,
    output logic             bank_sel_o,
    // interrupt
    output logic             irq_o
);

    // ========================================================
    // decode helpers
    function automatic logic hit(input logic [8:0] a,
                                 input logic [8:0] idx);
        hit = (a == idx);
    endfunction : hit
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : lane_mask

    // ========================================================
    // bus signals
    logic        req;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] wdata;
    logic [31:0] rd_mux;

    logic [7:0]  ep_state;
    logic [7:0]  ep_set;
    logic [7:0]  ep_clr;
    logic [7:0]  ep_flags_reg;
    logic [7:0]  ep_flags_next;
    logic [7:0]  ep_ien_reg;
    logic [15:0] host_flags_reg;
    logic [15:0] host_flags_next;
    logic [15:0] host_ien_reg;
    logic [15:0] host_ien_next;
    logic        attached_sync;
    logic        attached_prev_reg;
    logic        conn_evt;
    logic        disc_evt;
    logic        tok_in_reg;
    logic        pending;
    ueh_pkg::ueh_state_type state_reg;
    ueh_pkg::ueh_state_type state_next;

    // effects land on the edge where ack is seen high
    assign req    = cyc_i & stb_i;
    assign wr_acc = req & ack_o & we_i & ce_i;
    assign rd_acc = req & ack_o & ~we_i & ce_i;
    assign wdata  = dat_i & lane_mask(sel_i);

    // ack one cycle after the request, dropped after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= req & ~ack_o;
        end
    end

    // read mux; unmapped indices read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(adr_i, ueh_pkg::IDX_HOST_FLAGS))
            rd_mux = {16'h0000, host_flags_reg};
        else if (hit(adr_i, ueh_pkg::IDX_HOST_IEN_SET) ||
                 hit(adr_i, ueh_pkg::IDX_HOST_IEN_CLR))
            rd_mux = {16'h0000, host_ien_reg};
        else if (hit(adr_i, ueh_pkg::IDX_EP_STATE))
            rd_mux = {24'h00_0000, ep_state};
        else if (hit(adr_i, ueh_pkg::IDX_EP_FLAGS))
            rd_mux = {24'h00_0000, ep_flags_reg};
        else if (hit(adr_i, ueh_pkg::IDX_EP_IEN))
            rd_mux = {24'h00_0000, ep_ien_reg};
    end

    // read data captured with ack, cleared afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            dat_o <= (req & ~ack_o & ~we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // ========================================================
    // endpoint state strobes
    assign ep_set = (wr_acc && hit(adr_i, ueh_pkg::IDX_EP_SET))
                    ? wdata[7:0] : 8'h00;
    assign ep_clr = (wr_acc && hit(adr_i, ueh_pkg::IDX_EP_CLR))
                    ? wdata[7:0] : 8'h00;

    ueh_ep_state u_ep_state (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .ce_i          (ce_i),
        .sw_set_i      (ep_set),
        .sw_clr_i      (ep_clr),
        .setup_rcvd_i  (setup_rcvd_i),
        .in_ack_i      (in_ack_i),
        .out_data_ok_i (out_data_ok_i),
        .state_o       (ep_state)
    );

    // attach pin crosses in through two flops
    ueh_sync #(.W(1)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (dev_attached_i),
        .sync_o  (attached_sync)
    );

    // edge memory for connect and disconnect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            attached_prev_reg <= 1'b0;
        end else if (ce_i) begin
            attached_prev_reg <= attached_sync;
        end
    end
    assign conn_evt = attached_sync & ~attached_prev_reg;
    assign disc_evt = ~attached_sync & attached_prev_reg;

    // ========================================================
    // host enables: set and clear registers
    always_comb begin
        host_ien_next = host_ien_reg;
        if (wr_acc && hit(adr_i, ueh_pkg::IDX_HOST_IEN_CLR))
            host_ien_next = host_ien_reg & ~wdata[15:0];
        if (wr_acc && hit(adr_i, ueh_pkg::IDX_HOST_IEN_SET))
            host_ien_next = host_ien_reg | wdata[15:0];
        host_ien_next = host_ien_next & ueh_pkg::HOST_MASK;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_ien_reg <= ueh_pkg::HOST_RESET;
        end else if (ce_i) begin
            host_ien_reg <= host_ien_next;
        end
    end

    // host flags: sticky, cleared by read or one written
    always_comb begin
        host_flags_next = host_flags_reg;
        // only bits actually returned are cleared, so nothing
        // set after the read sample is lost
        if (rd_acc && hit(adr_i, ueh_pkg::IDX_HOST_FLAGS))
            host_flags_next = host_flags_next & ~dat_o[15:0];
        if (wr_acc && hit(adr_i, ueh_pkg::IDX_HOST_FLAGS))
            host_flags_next = host_flags_next & ~wdata[15:0];
        // events set last, so a set wins over a clear
        host_flags_next[ueh_pkg::B_UP_RESUME] |= up_resume_evt_i;
        host_flags_next[ueh_pkg::B_DN_RESUME] |= dn_resume_evt_i;
        host_flags_next[ueh_pkg::B_WAKE_UP]   |= wake_up_evt_i;
        host_flags_next[ueh_pkg::B_BUS_RESET] |= bus_reset_evt_i;
        host_flags_next[ueh_pkg::B_FRAME_ST]  |= frame_start_evt_i;
        host_flags_next[ueh_pkg::B_DEV_CONN]  |= conn_evt;
        host_flags_next[ueh_pkg::B_DEV_DISC]  |= disc_evt;
        host_flags_next = host_flags_next & ueh_pkg::HOST_MASK;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_flags_reg <= ueh_pkg::HOST_RESET;
        end else if (ce_i) begin
            host_flags_reg <= host_flags_next;
        end
    end

    // ========================================================
    // endpoint flags and their enables
    always_comb begin
        ep_flags_next = ep_flags_reg;
        if (rd_acc && hit(adr_i, ueh_pkg::IDX_EP_FLAGS))
            ep_flags_next = ep_flags_next & ~dat_o[7:0];
        if (wr_acc && hit(adr_i, ueh_pkg::IDX_EP_FLAGS))
            ep_flags_next = ep_flags_next & ~wdata[7:0];
        ep_flags_next[ueh_pkg::B_EP_SETUP]    |= setup_rcvd_i;
        ep_flags_next[ueh_pkg::B_EP_IN_DONE]  |= in_ack_i;
        ep_flags_next[ueh_pkg::B_EP_OUT_DONE] |= out_data_ok_i;
        ep_flags_next[ueh_pkg::B_EP_STALLED]  |=
            (state_reg == ueh_pkg::ST_RESPOND) &
            ep_state[ueh_pkg::B_STALL_REQ];
        ep_flags_next = ep_flags_next & ueh_pkg::EP_FLAG_MASK;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ep_flags_reg <= ueh_pkg::EP_FLAG_RESET;
            ep_ien_reg   <= ueh_pkg::EP_FLAG_RESET;
        end else if (ce_i) begin
            ep_flags_reg <= ep_flags_next;
            if (wr_acc && hit(adr_i, ueh_pkg::IDX_EP_IEN))
                ep_ien_reg <= wdata[7:0] & ueh_pkg::EP_FLAG_MASK;
        end
    end

    // interrupt from flags under their enables
    assign pending = |(host_flags_reg & host_ien_reg) |
                     |(ep_flags_reg & ep_ien_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= pending;
        end
    end

    // ========================================================
    // handshake sequencer: a token waits one cycle so that a
    // state write in the same cycle is seen by the answer
    always_comb begin
        case (state_reg)
            ueh_pkg::ST_IDLE:
                state_next = (in_token_i | out_token_i)
                             ? ueh_pkg::ST_RESPOND : ueh_pkg::ST_IDLE;
            ueh_pkg::ST_RESPOND:
                state_next = ueh_pkg::ST_IDLE;
            default:
                state_next = ueh_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg  <= ueh_pkg::ST_IDLE;
            tok_in_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            if (state_reg == ueh_pkg::ST_IDLE && (in_token_i | out_token_i))
                tok_in_reg <= in_token_i;
        end
    end

    // answer one cycle after the respond state: strobes pulse, pid and bank select hold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_stall_o  <= 1'b0;
            hs_nak_o    <= 1'b0;
            hs_ack_o    <= 1'b0;
            tx_data_o   <= 1'b0;
            pid_data1_o <= 1'b0;
            bank_sel_o  <= 1'b0;
        end else if (ce_i) begin
            hs_stall_o <= 1'b0;
            hs_nak_o   <= 1'b0;
            hs_ack_o   <= 1'b0;
            tx_data_o  <= 1'b0;
            if (state_reg == ueh_pkg::ST_RESPOND) begin
                bank_sel_o <= ep_state[ueh_pkg::B_CUR_BANK];
                if (ep_state[ueh_pkg::B_STALL_REQ]) begin
                    hs_stall_o <= 1'b1;
                end else if (tok_in_reg) begin
                    // data only from a filled bank
                    tx_data_o   <= ep_state[ueh_pkg::B_BANK0_READY];
                    hs_nak_o    <= ~ep_state[ueh_pkg::B_BANK0_READY];
                    pid_data1_o <= ep_state[ueh_pkg::B_IN_TOGGLE];
                end else begin
                    // a full bank refuses more data
                    hs_ack_o    <= ~ep_state[ueh_pkg::B_BANK0_READY];
                    hs_nak_o    <= ep_state[ueh_pkg::B_BANK0_READY];
                    pid_data1_o <= ep_state[ueh_pkg::B_OUT_TOGGLE];
                end
            end
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_bank_ready_set: assert property (
        (ep_set[ueh_pkg::B_BANK0_READY])
        |=> ep_state[ueh_pkg::B_BANK0_READY])
        else $error("bank ready not set by set write");
    a_bank_ready_clr: assert property (
        (ep_clr[ueh_pkg::B_BANK0_READY])
        |=> !ep_state[ueh_pkg::B_BANK0_READY])
        else $error("bank ready not cleared by clear write");
    a_stall_by_setup: assert property (
        (ce_i && setup_rcvd_i && !ep_set[ueh_pkg::B_STALL_REQ])
        |=> !ep_state[ueh_pkg::B_STALL_REQ])
        else $error("stall request survived a setup packet");
    a_stall_answer: assert property (
        (ce_i && state_reg == ueh_pkg::ST_RESPOND &&
         ep_state[ueh_pkg::B_STALL_REQ])
        |=> hs_stall_o && !tx_data_o && !hs_nak_o && !hs_ack_o)
        else $error("stalled endpoint did not answer stall");
    a_bank_select: assert property (
        (ce_i && state_reg == ueh_pkg::ST_RESPOND)
        |=> bank_sel_o == $past(ep_state[ueh_pkg::B_CUR_BANK]))
        else $error("bank select differs from current bank");
    a_cur_bank_write: assert property (
        (ep_clr[ueh_pkg::B_CUR_BANK] && !ep_set[ueh_pkg::B_CUR_BANK])
        |=> !ep_state[ueh_pkg::B_CUR_BANK])
        else $error("current bank not cleared");
    a_in_pid: assert property (
        (ce_i && state_reg == ueh_pkg::ST_RESPOND && tok_in_reg &&
         !ep_state[ueh_pkg::B_STALL_REQ] && ep_state[ueh_pkg::B_BANK0_READY])
        |=> tx_data_o && pid_data1_o == $past(ep_state[1]))
        else $error("IN data pid does not follow the toggle");
    a_out_pid: assert property (
        (ce_i && state_reg == ueh_pkg::ST_RESPOND && !tok_in_reg &&
         !ep_state[ueh_pkg::B_STALL_REQ] && !ep_state[ueh_pkg::B_BANK0_READY])
        |=> hs_ack_o && pid_data1_o == $past(ep_state[0]))
        else $error("OUT answer pid does not follow the toggle");
    a_enable_set: assert property (
        (wr_acc && hit(adr_i, ueh_pkg::IDX_HOST_IEN_SET))
        |=> ((host_ien_reg & $past(wdata[15:0]) & ueh_pkg::HOST_MASK)
             == ($past(wdata[15:0]) & ueh_pkg::HOST_MASK)))
        else $error("enable set write did not set enables");
    a_enable_keep: assert property (
        (ce_i && !(wr_acc && hit(adr_i, ueh_pkg::IDX_HOST_IEN_CLR)))
        |=> (($past(host_ien_reg) & ~host_ien_reg) == 16'h0000))
        else $error("enable dropped without a clear write");
    a_connect_flag: assert property (
        (ce_i && conn_evt) |=> host_flags_reg[ueh_pkg::B_DEV_CONN])
        else $error("connect flag not raised");
    a_irq_level: assert property (
        ce_i |=> irq_o == $past(pending))
        else $error("interrupt does not follow enabled flags");
    a_ack_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");
    c_stall_sent:  cover property (hs_stall_o);
    c_in_data:     cover property (tx_data_o && pid_data1_o);
    c_irq_rise:    cover property (!irq_o ##1 irq_o);
    c_disconnect:  cover property (host_flags_reg[ueh_pkg::B_DEV_DISC]);
endmodule : ueh_ctrl

// ---- sim/ueh_link_model.sv ----
// ============================================================
// ueh_link_model: far side, pulses link events, drives attach
// assumes one clock shared with the block under test
// ============================================================
`timescale 1ns/1ns
module ueh_link_model (
    // clock
    input  wire logic       clk_i,
    // events and attach pin
    output logic      [9:0] ev_o,
    output logic            attach_o
);
    // quiet link at start
    initial begin
        ev_o     = 10'h000;
        attach_o = 1'b0;
    end
    // one-cycle event pulse, launched just after an edge
    task automatic pulse(input int k);
        @(posedge clk_i);
        ev_o <= 10'h001 << k;
        @(posedge clk_i);
        ev_o <= 10'h000;
    endtask : pulse
    // slow level, the block synchronises it
    task automatic attach(input logic v);
        @(posedge clk_i);
        attach_o <= v;
    endtask : attach
endmodule : ueh_link_model

// ---- sim/testbench.sv ----
// ============================================================
// testbench: register, handshake and interrupt checks
// assumes ueh_ctrl top and ueh_link_model as far side
// ============================================================
`timescale 1ns/1ns
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        ce    = 1'b1;
    logic [3:0]  sel   = 4'h0;
    logic        we    = 1'b0;
    logic [8:0]  adr   = 9'h000;
    logic [31:0] dat   = 32'h00000000;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic [3:0]  hs;
    logic [9:0]  ev;
    logic        ack_o, irq_o, att, pid1, bsel;
    int          err_total = 0;
    int          checks = 0;
    int          ek[5] = '{2, 0, 1, 3, 4};
    int          bt[5] = '{6, 3, 2, 5, 4};
    ueh_link_model link (.clk_i(clk_i), .ev_o(ev), .attach_o(att));
    ueh_ctrl ueh_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc),
        .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .bus_reset_evt_i(ev[0]), .frame_start_evt_i(ev[1]),
        .up_resume_evt_i(ev[2]), .dn_resume_evt_i(ev[3]),
        .wake_up_evt_i(ev[4]), .setup_rcvd_i(ev[5]),
        .in_token_i(ev[6]), .out_token_i(ev[7]), .in_ack_i(ev[8]),
        .out_data_ok_i(ev[9]), .dev_attached_i(att),
        .hs_stall_o(hs[3]), .hs_nak_o(hs[2]), .hs_ack_o(hs[1]),
        .tx_data_o(hs[0]), .pid_data1_o(pid1), .bank_sel_o(bsel),
        .irq_o(irq_o));
    initial forever #20 clk_i = ~clk_i;
    // verdict and end of run, the only exit
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // classic cycle: hold until ack sampled, then one idle cycle
    task automatic wb(input logic w, input logic [8:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        sel <= 4'hF;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            err_total++;
            stop_test();
        end
        q = dat_o;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rc(input logic [8:0] a, input logic [31:0] e,
                      input string n);
        wb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rc
    // token, then the answer pulse within a few cycles
    task automatic tok(input int k, input logic [3:0] e);
        int n;
        n = 0;
        link.pulse(k);
        #1;
        while (hs === 4'h0 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("answer", {28'h0, e}, {28'h0, hs});
    endtask : tok
    task automatic irq_is(input logic e);
        @(posedge clk_i);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq_o});
    endtask : irq_is
    // hang guard: a bound that runs out counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(ueh_pkg::IDX_HOST_FLAGS, 32'h0, "flags");
        rc(ueh_pkg::IDX_EP_STATE, 32'h0, "state");
        wb(1'b1, ueh_pkg::IDX_EP_SET, 32'h57);
        rc(ueh_pkg::IDX_EP_STATE, 32'h57, "set");
        wb(1'b1, ueh_pkg::IDX_EP_CLR, 32'h41);
        rc(ueh_pkg::IDX_EP_STATE, 32'h16, "clr");
        tok(6, 4'h8);
        link.pulse(5);
        rc(ueh_pkg::IDX_EP_STATE, 32'h06, "setup");
        tok(6, 4'h4);
        chk("pid", 32'h1, pid1);
        chk("bank", 32'h1, bsel);
        wb(1'b1, ueh_pkg::IDX_EP_SET, 32'h40);
        tok(6, 4'h1);
        tok(7, 4'h4);
        wb(1'b1, ueh_pkg::IDX_EP_CLR, 32'h42);
        wb(1'b1, ueh_pkg::IDX_EP_SET, 32'h01);
        tok(7, 4'h2);
        chk("pid", 32'h1, pid1);
        link.pulse(9);
        link.pulse(8);
        rc(ueh_pkg::IDX_EP_STATE, 32'h06, "hw");
        rc(ueh_pkg::IDX_EP_FLAGS, 32'h33, "epflags");
        wb(1'b1, ueh_pkg::IDX_HOST_IEN_SET, 32'h3C);
        wb(1'b1, ueh_pkg::IDX_HOST_IEN_SET, 32'h0);
        rc(ueh_pkg::IDX_HOST_IEN_SET, 32'h3C, "ien");
        link.pulse(2);
        irq_is(1'b0);
        wb(1'b1, ueh_pkg::IDX_HOST_IEN_SET, 32'h40);
        irq_is(1'b1);
        // each event raises its flag, read clears it
        for (int k = 0; k < 5; k++) begin
            if (k > 0)
                link.pulse(ek[k]);
            irq_is(1'b1);
            rc(ueh_pkg::IDX_HOST_FLAGS, 32'h1 << bt[k], "flag");
            irq_is(1'b0);
        end
        // enable low: an event in that cycle is not taken
        @(posedge clk_i);
        ce <= 1'b0;
        link.pulse(0);
        ce <= 1'b1;
        rc(ueh_pkg::IDX_HOST_FLAGS, 32'h0, "frozen");
        wb(1'b1, ueh_pkg::IDX_HOST_IEN_CLR, 32'h40);
        rc(ueh_pkg::IDX_HOST_IEN_SET, 32'h3C, "ienclr");
        link.attach(1'b1);
        repeat (6) @(posedge clk_i);
        rc(ueh_pkg::IDX_HOST_FLAGS, 32'h100, "conn");
        link.attach(1'b0);
        repeat (6) @(posedge clk_i);
        rc(ueh_pkg::IDX_HOST_FLAGS, 32'h200, "disc");
        // second reset in mid-run
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(ueh_pkg::IDX_EP_STATE, 32'h0, "rst");
        rc(ueh_pkg::IDX_HOST_IEN_SET, 32'h0, "rstien");
        rc(9'h050, 32'h0, "unmapped");
        stop_test();
    end
endmodule : testbench
